// file: inc/clr_pkg.sv
package clr_pkg;
    localparam int          CLR_AW            = 8;
    localparam int          CLR_DW            = 32;
    // register byte address
    localparam logic [7:0]  CLR_SETTINGS_OFS  = 8'h88;
    // status word offset
    localparam logic [7:0]  CLR_STATUS_OFS    = 8'h8C;
    localparam logic [31:0] CLR_SETTINGS_RST  = 32'h0000_0000;
    localparam int          CLR_RSVD_BIT      = 31;
    localparam int          CLR_OVERDRIVE_BIT = 30;
    localparam int          CLR_ACC_HI        = 29;
    localparam int          CLR_ACC_LO        = 25;
    localparam int          CLR_DSRC_BIT      = 24;
    localparam int          CLR_DEC_HI        = 23;
    localparam int          CLR_DEC_LO        = 19;
    localparam int          CLR_SURGE_BIT     = 3;
    localparam int          CLR_CODE_W        = 5;
    localparam int          CLR_RATE_W        = 20;
    // accel/decel code that means no rate limit
    localparam logic [4:0]  CLR_NO_LIMIT_CODE = 5'h1F;
    localparam logic [19:0] CLR_RATE_MAX      = 20'hF_FFFF;
endpackage

// file: rtl/clr_rate_lut.sv
`timescale 1ns/1ps
`default_nettype none
module clr_rate_lut (
    input  wire logic [clr_pkg::CLR_CODE_W-1:0] code_i,
    output logic      [clr_pkg::CLR_RATE_W-1:0] rate_o,
    output logic                                unlimited_o
);
    import clr_pkg::*;

    // rate in units of 0.1 Hz/s
    function automatic logic [CLR_RATE_W-1:0] rate_of(input logic [CLR_CODE_W-1:0] c);
        logic [CLR_RATE_W-1:0] r;
        r = CLR_RATE_MAX;
        unique case (c)
            5'h00: r = 20'h0_0005;
            5'h01: r = 20'h0_000A;
            5'h02: r = 20'h0_0019;
            5'h03: r = 20'h0_0032;
            5'h04: r = 20'h0_004B;
            5'h05: r = 20'h0_0064;
            5'h06: r = 20'h0_00C8;
            5'h07: r = 20'h0_0190;
            5'h08: r = 20'h0_0258;
            5'h09: r = 20'h0_0320;
            5'h0A: r = 20'h0_03E8;
            5'h0B: r = 20'h0_07D0;
            5'h0C: r = 20'h0_0BB8;
            5'h0D: r = 20'h0_0FA0;
            5'h0E: r = 20'h0_1388;
            5'h0F: r = 20'h0_1770;
            5'h10: r = 20'h0_1B58;
            5'h11: r = 20'h0_1F40;
            5'h12: r = 20'h0_2328;
            5'h13: r = 20'h0_2710;
            5'h14: r = 20'h0_4E20;
            5'h15: r = 20'h0_9C40;
            5'h16: r = 20'h0_EA60;
            5'h17: r = 20'h1_3880;
            5'h18: r = 20'h1_86A0;
            5'h19: r = 20'h3_0D40;
            5'h1A: r = 20'h4_93E0;
            5'h1B: r = 20'h6_1A80;
            5'h1C: r = 20'h7_A120;
            5'h1D: r = 20'h9_27C0;
            5'h1E: r = 20'hA_AE60;
            5'h1F: r = CLR_RATE_MAX;
        endcase
        return r;
    endfunction

    assign rate_o      = rate_of(code_i);
    assign unlimited_o = (code_i == CLR_NO_LIMIT_CODE);
endmodule
`default_nettype wire

// file: rtl/clr_config.sv
// Operation
// - bit 30 enables drive overmodulation
// - bits 29:25 set accel limit code
// - source bit 0 selects decel field
// - source bit 1 reuses accel code
// - decel field sets decel limit whenever source bit is 0, surge guard or not; status bit 2 shows it only with surge guard off
`timescale 1ns/1ps
`default_nettype none
module clr_config (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    input  wire logic [clr_pkg::CLR_AW-1:0]   adr_i,
    input  wire logic [clr_pkg::CLR_DW-1:0]   dat_i,
    input  wire logic [3:0]                   sel_i,
    input  wire logic                         we_i,
    input  wire logic                         cyc_i,
    input  wire logic                         stb_i,
    output logic      [clr_pkg::CLR_DW-1:0]   dat_o,
    output logic                              ack_o,
    output logic                              err_o,
    output logic                              drive_overdrive_on_o,
    output logic      [clr_pkg::CLR_RATE_W-1:0] accel_limit_o,
    output logic                              accel_unlimited_o,
    output logic      [clr_pkg::CLR_RATE_W-1:0] decel_limit_o,
    output logic                              decel_unlimited_o,
    output logic                              surge_guard_on_o
);
    import clr_pkg::*;

    logic [CLR_DW-1:0]     closed_loop_settings_one;
    logic [CLR_DW-1:0]     next_settings;
    logic [CLR_DW-1:0]     byte_mask;
    logic [CLR_DW-1:0]     read_word;
    logic [CLR_DW-1:0]     status_word;
    logic [CLR_CODE_W-1:0] closed_loop_accel_rate;
    logic [CLR_CODE_W-1:0] closed_loop_decel_rate;
    logic [CLR_CODE_W-1:0] decel_code;
    logic [CLR_RATE_W-1:0] acc_rate;
    logic [CLR_RATE_W-1:0] dec_rate;
    logic                  acc_unl;
    logic                  dec_unl;
    logic                  decel_rate_source;
    logic                  surge_guard_on;
    logic                  req;
    logic                  hit_set;
    logic                  hit_stat;
    logic                  do_write;
    logic                  decel_from_field;
    logic                  drive_overdrive_on_w;

    // one cycle answer; drop after ack so back-to-back sees a gap
    assign req      = cyc_i & stb_i & ~ack_o & ~err_o;
    assign hit_set  = (adr_i == CLR_SETTINGS_OFS);
    assign hit_stat = (adr_i == CLR_STATUS_OFS);
    assign do_write = req & we_i & hit_set;

    assign byte_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    assign next_settings = (closed_loop_settings_one & ~byte_mask) | (dat_i & byte_mask);

    assign drive_overdrive_on_w = closed_loop_settings_one[CLR_OVERDRIVE_BIT];
    assign closed_loop_accel_rate = closed_loop_settings_one[CLR_ACC_HI:CLR_ACC_LO];
    assign closed_loop_decel_rate = closed_loop_settings_one[CLR_DEC_HI:CLR_DEC_LO];
    assign decel_rate_source      = closed_loop_settings_one[CLR_DSRC_BIT];
    assign surge_guard_on         = closed_loop_settings_one[CLR_SURGE_BIT];

    assign decel_from_field = ~decel_rate_source & ~surge_guard_on;
    assign decel_code = decel_rate_source ? closed_loop_accel_rate : closed_loop_decel_rate;

    clr_rate_lut u_acc (
        .code_i      (closed_loop_accel_rate),
        .rate_o      (acc_rate),
        .unlimited_o (acc_unl)
    );

    clr_rate_lut u_dec (
        .code_i      (decel_code),
        .rate_o      (dec_rate),
        .unlimited_o (dec_unl)
    );

    // status: effective decel path and flags
    assign status_word = {28'h000_0000, surge_guard_on, decel_from_field, dec_unl, acc_unl};
    assign read_word   = hit_set ? closed_loop_settings_one : (hit_stat ? status_word : 32'h0000_0000);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            closed_loop_settings_one <= CLR_SETTINGS_RST;
        end else if (do_write) begin
            closed_loop_settings_one <= next_settings;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req & (hit_set | (hit_stat & ~we_i));
            err_o <= req & ~(hit_set | (hit_stat & ~we_i));
            dat_o <= (req & ~we_i) ? read_word : 32'h0000_0000;
        end
    end

    // limits follow the register one cycle later
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drive_overdrive_on_o <= 1'b0;
            accel_limit_o        <= 20'h0_0000;
            accel_unlimited_o    <= 1'b0;
            decel_limit_o        <= 20'h0_0000;
            decel_unlimited_o    <= 1'b0;
            surge_guard_on_o     <= 1'b0;
        end else begin
            drive_overdrive_on_o <= drive_overdrive_on_w;
            accel_limit_o        <= acc_rate;
            accel_unlimited_o    <= acc_unl;
            decel_limit_o        <= dec_rate;
            decel_unlimited_o    <= dec_unl;
            surge_guard_on_o     <= surge_guard_on;
        end
    end
endmodule
`default_nettype wire

// file: testbench/clr_config_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module clr_config_assertions
    import clr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        we_i,
    input  wire logic        ack_o,
    input  wire logic        err_o,
    input  wire logic        drive_overdrive_on_o,
    input  wire logic [19:0] accel_limit_o,
    input  wire logic        accel_unlimited_o,
    input  wire logic [19:0] decel_limit_o,
    input  wire logic        decel_unlimited_o,
    input  wire logic        surge_guard_on_o
);
    wire wr = ack_o && we_i && adr_i == CLR_SETTINGS_OFS;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_overdrive_set: assert property (wr && sel_i[3] |=> drive_overdrive_on_o == $past(dat_i[30]))
        else $error("overdrive bit wrong");
    a_accel_unlim: assert property (accel_unlimited_o == (accel_limit_o == CLR_RATE_MAX))
        else $error("accel unlimited flag wrong");
    a_accel_nolimit: assert property (wr && sel_i[3] |=> accel_unlimited_o == ($past(dat_i[29:25]) == 5'h1F))
        else $error("accel no-limit code not decoded");
    a_decel_field: assert property (wr && sel_i[3] && sel_i[2] && !dat_i[24] && dat_i[23:19] == 5'h1F |=> decel_unlimited_o)
        else $error("decel field ignored");
    a_decel_reuse: assert property (wr && sel_i[3] && dat_i[24] |=> decel_limit_o == accel_limit_o)
        else $error("decel not following accel");
    a_surge_bit: assert property (wr && sel_i[0] |=> surge_guard_on_o == $past(dat_i[3]))
        else $error("surge guard bit wrong");
    a_err_unmapped: assert property (err_o |-> !ack_o && adr_i != CLR_SETTINGS_OFS)
        else $error("error on settings access");
    cover property (wr && dat_i[24]);
    cover property (err_o);
    cover property (accel_unlimited_o);
endmodule
bind clr_config clr_config_assertions u_chk (.*);
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import clr_pkg::*;
    logic        clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, ack_o, err_o, ovr, au, du, sg;
    logic [7:0]  adr = 0;
    logic [3:0]  sel = 0, s;
    logic [4:0]  c;
    logic [31:0] dat = 0, dat_o, m = 0, d, k;
    logic [19:0] al, dl;
    logic [32:0] q[$];
    integer      seed = 32'h67c2, num_errors = 0, n_compared = 0, cycles = 0;
    logic [19:0] tbl[32] = '{20'h5, 20'hA, 20'h19, 20'h32, 20'h4B, 20'h64, 20'hC8, 20'h190, 20'h258, 20'h320,
        20'h3E8, 20'h7D0, 20'hBB8, 20'hFA0, 20'h1388, 20'h1770, 20'h1B58, 20'h1F40, 20'h2328, 20'h2710, 20'h4E20,
        20'h9C40, 20'hEA60, 20'h1_3880, 20'h1_86A0, 20'h3_0D40, 20'h4_93E0, 20'h6_1A80, 20'h7_A120, 20'h9_27C0,
        20'hA_AE60, 20'hF_FFFF};
    always #5 clk_i = ~clk_i;
    clr_config u_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat), .sel_i(sel), .we_i(we), .cyc_i(cyc),
        .stb_i(stb), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .drive_overdrive_on_o(ovr), .accel_limit_o(al),
        .accel_unlimited_o(au), .decel_limit_o(dl), .decel_unlimited_o(du), .surge_guard_on_o(sg));
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // one classic cycle, held until ack or err is sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v, input logic [3:0] b,
        input logic [32:0] e);
        q.push_back(e);
        @(posedge clk_i);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, v, b};
        do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
        {cyc, stb} <= 2'b00;
        #1;
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (ack_o === 1'b1 || err_o === 1'b1) chk({err_o, dat_o}, q.pop_front());
        if (cycles == 3000) begin
            num_errors++;
            print_verdict;
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        bus(0, CLR_SETTINGS_OFS, 0, 4'hF, 33'h0);
        chk({au, du, 11'h0, al}, {2'b0, 11'h0, tbl[0]});
        chk({ovr, sg, 11'h0, dl}, {2'b0, 11'h0, tbl[0]});
        for (int i = 0; i < 64; i++) begin
            d = $random(seed);
            s = (i < 32) ? 4'hF : 4'($random(seed));
            if (i < 32) d[29:19] = {i[4:0], i[0], ~i[4:0]};
            bus(1, CLR_SETTINGS_OFS, d, s, 33'h0);
            k = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
            m = (m & ~k) | (d & k);
            c = m[24] ? m[29:25] : m[23:19];
            chk(33'(ovr), 33'(m[30]));
            chk({au, 12'h0, al}, {m[29:25] == 5'h1F, 12'h0, tbl[m[29:25]]});
            chk({du, 12'h0, dl}, {c == 5'h1F, 12'h0, tbl[c]});
            chk(33'(sg), 33'(m[3]));
            bus(0, CLR_STATUS_OFS, 0, 4'hF, {29'h0, m[3], !m[24] && !m[3], c == 5'h1F, m[29:25] == 5'h1F});
            bus(0, CLR_SETTINGS_OFS, 0, 4'hF, {1'b0, m});
        end
        bus(0, 8'h90, 0, 4'hF, 33'h1_0000_0000);
        bus(1, CLR_STATUS_OFS, '1, 4'hF, 33'h1_0000_0000);
        bus(0, CLR_SETTINGS_OFS, 0, 4'hF, {1'b0, m});
        repeat (2) @(posedge clk_i);
        print_verdict;
    end
endmodule
`default_nettype wire
